// ==== logic/stuwc_pkg.sv ====
// constants for the short-threshold, serial-link config and link watchdog slice
package stuwc_pkg;

  localparam int unsigned REG_W          = 13;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned THR_W          = 3;
  localparam int unsigned SEL_W          = 4;
  localparam int unsigned CID_W          = 6;
  localparam int unsigned SW_N           = 12;
  localparam int unsigned TICKS_W        = 16;

  // ----------------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFF_SHORT_LO   = 8'h05;
  localparam logic [7:0]  OFF_SHORT_HI   = 8'h06;
  localparam logic [7:0]  OFF_SERIAL     = 8'h07;
  localparam logic [12:0] RST_SHORT      = 13'h0000;
  localparam logic [5:0]  RST_CID        = 6'h01;
  localparam logic [3:0]  RST_SEL        = 4'h0;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned THR_LSB_A      = 0;
  localparam int unsigned THR_LSB_B      = 3;
  localparam int unsigned THR_LSB_C      = 6;
  localparam int unsigned THR_LSB_D      = 9;
  localparam int unsigned SEL_LSB        = 6;
  localparam int unsigned CID_LSB        = 0;
  localparam logic [12:0] SHORT_MASK     = 13'h0fff;

  // ----------------------------------------------------------------------
  // timing: watchdog counts in ticks of a fixed base time
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned TICK_US        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  // durations in microseconds per select code, code 0 = disabled
  localparam int unsigned WDOG_US [16]   = '{0, 200, 500, 1000, 2000, 5000, 10000, 20000,
                                             50000, 100000, 200000, 500000, 1000000,
                                             2000000, 5000000, 5000000};

endpackage

// ==== logic/stuwc_wdog_timer.sv ====
// link inactivity timer: prescaler plus tick counter, one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module stuwc_wdog_timer
  import stuwc_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               restart,
  input  wire logic               run,
  input  wire logic [TICKS_W-1:0] limit,
  output logic                    expire
);

  logic [15:0]        pre_q;
  logic [15:0]        pre_d;
  logic [TICKS_W-1:0] ticks_q;
  logic [TICKS_W-1:0] ticks_d;
  logic               exp_q;
  logic               exp_d;
  logic               tick;

  always_comb begin
    tick    = (pre_q == 16'(TICK_LEN - 1));
    pre_d   = tick ? 16'h0000 : pre_q + 16'h0001;
    ticks_d = ticks_q;
    exp_d   = 1'b0;
    if (tick) begin
      if (ticks_q == limit - 16'h0001) begin
        ticks_d = 16'h0000;
        exp_d   = 1'b1;
      end else begin
        ticks_d = ticks_q + 16'h0001;
      end
    end
    // a stopped or restarted timer holds at zero so the full span is measured
    if (restart || !run) begin
      pre_d   = 16'h0000;
      ticks_d = 16'h0000;
      exp_d   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_q   <= 16'h0000;
      ticks_q <= 16'h0000;
      exp_q   <= 1'b0;
    end else begin
      pre_q   <= pre_d;
      ticks_q <= ticks_d;
      exp_q   <= exp_d;
    end
  end

  assign expire = exp_q;

endmodule
`default_nettype wire

// ==== logic/stuwc_cfg_regs.sv ====
// short-threshold and serial-link config registers with link watchdog
`timescale 1ns/1ps
`default_nettype none
module stuwc_cfg_regs
  import stuwc_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [REG_W-1:0]  reg_wdata,
  output logic      [REG_W-1:0]  reg_rdata_q,
  input  wire logic              cmd_valid,
  input  wire logic              cluster_req,
  input  wire logic [CID_W-1:0]  cluster_ident_rx,
  output logic                   cluster_accept_q,
  input  wire logic [SW_N-1:0]   timeout_switch_pattern,
  input  wire logic [SW_N-1:0]   normal_switch_state,
  output logic      [SW_N-1:0]   switch_drive_q,
  output logic                   fault_output_q,
  output logic                   link_timeout_status_q,
  output logic      [THR_W-1:0]  short_threshold_sw5,
  output logic      [THR_W-1:0]  short_threshold_sw6,
  output logic      [THR_W-1:0]  short_threshold_sw7,
  output logic      [THR_W-1:0]  short_threshold_sw8,
  output logic      [THR_W-1:0]  short_threshold_sw9,
  output logic      [THR_W-1:0]  short_threshold_sw10,
  output logic      [THR_W-1:0]  short_threshold_sw11,
  output logic      [THR_W-1:0]  short_threshold_sw12
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [REG_W-1:0] short_lo_q;
  logic [REG_W-1:0] short_lo_d;
  logic [REG_W-1:0] short_hi_q;
  logic [REG_W-1:0] short_hi_d;
  logic [SEL_W-1:0] sel_q;
  logic [SEL_W-1:0] sel_d;
  logic [CID_W-1:0] cid_q;
  logic [CID_W-1:0] cid_d;
  logic [REG_W-1:0] rdata_d;
  logic             wr_lo;
  logic             wr_hi;
  logic             wr_serial;

  always_comb begin
    wr_lo      = reg_wr_en && (reg_addr == OFF_SHORT_LO);
    wr_hi      = reg_wr_en && (reg_addr == OFF_SHORT_HI);
    wr_serial  = reg_wr_en && (reg_addr == OFF_SERIAL);
    short_lo_d = wr_lo ? (reg_wdata & SHORT_MASK) : short_lo_q;
    short_hi_d = wr_hi ? (reg_wdata & SHORT_MASK) : short_hi_q;
    sel_d      = wr_serial ? reg_wdata[SEL_LSB +: SEL_W] : sel_q;
    cid_d      = wr_serial ? reg_wdata[CID_LSB +: CID_W] : cid_q;
    rdata_d    = reg_rdata_q;
    if (reg_rd_en) begin
      case (reg_addr)
        OFF_SHORT_LO: rdata_d = short_lo_q;
        OFF_SHORT_HI: rdata_d = short_hi_q;
        OFF_SERIAL:   rdata_d = {3'h0, sel_q, cid_q};
        default:      rdata_d = 13'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      short_lo_q  <= RST_SHORT;
      short_hi_q  <= RST_SHORT;
      sel_q       <= RST_SEL;
      cid_q       <= RST_CID;
      reg_rdata_q <= 13'h0000;
    end else begin
      short_lo_q  <= short_lo_d;
      short_hi_q  <= short_hi_d;
      sel_q       <= sel_d;
      cid_q       <= cid_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // codes pass straight to the comparators; the voltage decode lives there
  assign short_threshold_sw5  = short_lo_q[THR_LSB_A +: THR_W];
  assign short_threshold_sw6  = short_lo_q[THR_LSB_B +: THR_W];
  assign short_threshold_sw7  = short_lo_q[THR_LSB_C +: THR_W];
  assign short_threshold_sw8  = short_lo_q[THR_LSB_D +: THR_W];
  assign short_threshold_sw9  = short_hi_q[THR_LSB_A +: THR_W];
  assign short_threshold_sw10 = short_hi_q[THR_LSB_B +: THR_W];
  assign short_threshold_sw11 = short_hi_q[THR_LSB_C +: THR_W];
  assign short_threshold_sw12 = short_hi_q[THR_LSB_D +: THR_W];

  // ----------------------------------------------------------------------
  // link watchdog
  // ----------------------------------------------------------------------
  logic               wd_restart;
  logic               wd_expire;
  logic [TICKS_W-1:0] wd_limit;

  always_comb begin
    wd_restart = cmd_valid || wr_serial;
    wd_limit   = TICKS_W'(WDOG_US[sel_q] / TICK_US);
  end

  stuwc_wdog_timer #(
    .TICK_LEN (TICK_LEN)
  ) u_wdog (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (wd_restart),
    .run     (sel_q != 4'h0),
    .limit   (wd_limit),
    .expire  (wd_expire)
  );

  // ----------------------------------------------------------------------
  // status, fault pin, switch override, cluster match
  // ----------------------------------------------------------------------
  logic            status_d;
  logic            fault_d;
  logic            accept_d;
  logic [SW_N-1:0] drive_d;

  always_comb begin
    // a new valid command ends the timeout; an expiry in that cycle still wins
    status_d = (link_timeout_status_q && !cmd_valid) || wd_expire;
    fault_d  = link_timeout_status_q;
    drive_d  = link_timeout_status_q ? timeout_switch_pattern : normal_switch_state;
    accept_d = cluster_req && (cluster_ident_rx == cid_q);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_timeout_status_q <= 1'b0;
      fault_output_q        <= 1'b0;
      switch_drive_q        <= 12'h000;
      cluster_accept_q      <= 1'b0;
    end else begin
      link_timeout_status_q <= status_d;
      fault_output_q        <= fault_d;
      switch_drive_q        <= drive_d;
      cluster_accept_q      <= accept_d;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_restart;
    wd_restart;
  endsequence

  sequence s_quiet;
    !wd_expire [*8];
  endsequence

  a_reset_values: assert property ($fell(sys_rst) |-> short_lo_q == 13'h0000
    && short_hi_q == 13'h0000 && cid_q == 6'h01 && sel_q == 4'h0)
    else $error("config registers not at reset values");
  a_write_low: assert property (wr_lo |=> short_threshold_sw8 == $past(reg_wdata[11:9])
    && short_threshold_sw5 == $past(reg_wdata[2:0]))
    else $error("switch 5 to 8 threshold write lost");
  a_write_high: assert property (wr_hi |=> short_threshold_sw11 == $past(reg_wdata[8:6])
    && short_threshold_sw10 == $past(reg_wdata[5:3]))
    else $error("switch 9 to 12 threshold write lost");
  a_sel_write: assert property (wr_serial |=> sel_q == $past(reg_wdata[9:6]))
    else $error("timeout select not taken from bits 9:6");
  a_wdog_off: assert property (sel_q == 4'h0 |=> !wd_expire)
    else $error("watchdog expired while disabled");
  a_flag_set: assert property (wd_expire |=> link_timeout_status_q ##1 fault_output_q)
    else $error("expiry did not raise flag and fault");
  a_fault_pin: assert property (!$past(sys_rst) |->
    fault_output_q == $past(link_timeout_status_q))
    else $error("fault pin does not follow timeout flag");
  a_sw_pattern: assert property (link_timeout_status_q |=>
    switch_drive_q == $past(timeout_switch_pattern))
    else $error("switches not forced to timeout pattern");
  a_cluster_match: assert property (cluster_req |=>
    cluster_accept_q == ($past(cluster_ident_rx) == $past(cid_q)))
    else $error("cluster call acceptance wrong");
  a_serial_read: assert property (reg_rd_en && reg_addr == OFF_SERIAL |=>
    reg_rdata_q == {3'h0, $past(sel_q), $past(cid_q)})
    else $error("serial config readback wrong");
  a_kick_restart: assert property (s_restart |=> s_quiet)
    else $error("expiry too soon after restart");

  // flag, pin, readback, cluster and reset bookkeeping: only a command without a fresh expiry clears the flag
  a_fault_pattern: assert property (fault_output_q |->
    switch_drive_q == $past(timeout_switch_pattern))
    else $error("fault raised without timeout pattern");
  a_normal_drive: assert property (!link_timeout_status_q |=>
    switch_drive_q == $past(normal_switch_state))
    else $error("switches not following normal control");
  a_flag_clear: assert property (link_timeout_status_q && cmd_valid && !wd_expire |=>
    !link_timeout_status_q)
    else $error("timeout flag not cleared by valid command");
  a_flag_sticky: assert property (link_timeout_status_q && !cmd_valid |=> link_timeout_status_q)
    else $error("timeout flag dropped without command");
  a_low_read: assert property (reg_rd_en && reg_addr == OFF_SHORT_LO |=>
    reg_rdata_q == $past(short_lo_q))
    else $error("switch 5 to 8 threshold readback wrong");
  a_high_read: assert property (reg_rd_en && reg_addr == OFF_SHORT_HI |=>
    reg_rdata_q == $past(short_hi_q))
    else $error("switch 9 to 12 threshold readback wrong");
  a_unmapped_read: assert property (reg_rd_en && reg_addr != OFF_SHORT_LO
    && reg_addr != OFF_SHORT_HI && reg_addr != OFF_SERIAL |=>
    reg_rdata_q == 13'h0000)
    else $error("unmapped offset did not read zero");
  a_read_hold: assert property (!reg_rd_en |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
  a_idle_accept: assert property (!cluster_req |=> !cluster_accept_q)
    else $error("cluster accept without a cluster call");
  a_cid_write: assert property (wr_serial |=> cid_q == $past(reg_wdata[5:0]))
    else $error("cluster identifier not taken from bits 5:0");
  a_reset_outputs: assert property ($fell(sys_rst) |-> !link_timeout_status_q
    && !fault_output_q && switch_drive_q == 12'h000 && !cluster_accept_q)
    else $error("status outputs not at reset values");

endmodule
`default_nettype wire

// ==== dv/stuwc_host_model.sv ====
// host-side model: register strobes, serial command pulses, cluster calls
`timescale 1ns/1ps
`default_nettype none
module stuwc_host_model
  import stuwc_pkg::*;
(
  input  wire logic              clk,
  output logic                   reg_wr_en,
  output logic                   reg_rd_en,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [REG_W-1:0]  reg_wdata,
  output logic                   cmd_valid,
  output logic                   cluster_req,
  output logic      [CID_W-1:0]  cluster_ident_rx,
  output logic      [SW_N-1:0]   timeout_switch_pattern,
  output logic      [SW_N-1:0]   normal_switch_state
);
  // host's own switch-activation enable, never sent to this slice
  logic switch_activation_enable;

  initial begin
    {reg_wr_en, reg_rd_en, cmd_valid, cluster_req} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 13'h0000;
    cluster_ident_rx = 6'h00;
    timeout_switch_pattern = 12'ha5c;
    normal_switch_state = 12'h3c3;
    switch_activation_enable = 1'b1;
  end

  // released lines show the inverse so a stale value is never mistaken for live data
  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    if (a == OFF_SHORT_LO || a == OFF_SHORT_HI) switch_activation_enable = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1 reg_rd_en = 1'b0;
    reg_addr = ~a;
    @(posedge clk);
    #1;
  endtask

  task automatic cmd;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
  endtask

  task automatic cl(input logic [5:0] id);
    cluster_ident_rx = id;
    cluster_req = 1'b1;
    @(posedge clk);
    #1 cluster_req = 1'b0;
    cluster_ident_rx = ~id;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_short_threshold_uart_wdog_cfg.sv ====
// self-checking bench for the threshold and serial-link config slice
`timescale 1ns/1ps
`default_nettype none
module tb_short_threshold_uart_wdog_cfg
  import stuwc_pkg::*;
;
  localparam int unsigned TL = 4;
  logic              clk, sys_rst, reg_wr_en, reg_rd_en, cmd_valid, cluster_req;
  logic              cluster_accept_q, fault_output_q, link_timeout_status_q;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0]  reg_wdata, reg_rdata_q;
  logic [CID_W-1:0]  cluster_ident_rx;
  logic [SW_N-1:0]   timeout_switch_pattern, normal_switch_state, switch_drive_q;
  logic [THR_W-1:0]  short_threshold_sw5, short_threshold_sw6, short_threshold_sw7;
  logic [THR_W-1:0]  short_threshold_sw8, short_threshold_sw9, short_threshold_sw10;
  logic [THR_W-1:0]  short_threshold_sw11, short_threshold_sw12;
  int                err_total = 0, checks_done = 0, cyc = 0, n;
  int                nt [3] = '{2, 5, 10};
  logic [3:0]        sel [3] = '{4'h1, 4'h2, 4'h3};

  stuwc_cfg_regs #(.TICK_LEN(TL)) uut (.clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata_q, .cmd_valid, .cluster_req, .cluster_ident_rx, .cluster_accept_q,
    .timeout_switch_pattern, .normal_switch_state, .switch_drive_q, .fault_output_q,
    .link_timeout_status_q, .short_threshold_sw5, .short_threshold_sw6, .short_threshold_sw7,
    .short_threshold_sw8, .short_threshold_sw9, .short_threshold_sw10, .short_threshold_sw11,
    .short_threshold_sw12);
  stuwc_host_model host (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .cmd_valid,
    .cluster_req, .cluster_ident_rx, .timeout_switch_pattern, .normal_switch_state);

  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      test_done;
    end
  end

  initial begin
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk({1'b0, switch_drive_q}, 13'h0000);
    host.rd(OFF_SHORT_LO);
    chk(reg_rdata_q, 13'h0000);
    host.rd(OFF_SHORT_HI);
    chk(reg_rdata_q, 13'h0000);
    host.rd(OFF_SERIAL);
    chk(reg_rdata_q, 13'h0001);
    $display("test reset values done");
    host.wr(OFF_SHORT_LO, 13'h1fac);
    host.wr(OFF_SHORT_HI, 13'h1053);
    host.wr(8'h08, 13'h1fff);
    host.rd(OFF_SHORT_LO);
    chk(reg_rdata_q, 13'h0fac);
    chk({1'b0, short_threshold_sw8, short_threshold_sw7, short_threshold_sw6,
         short_threshold_sw5}, 13'h0fac);
    host.rd(OFF_SHORT_HI);
    chk(reg_rdata_q, 13'h0053);
    chk({1'b0, short_threshold_sw12, short_threshold_sw11, short_threshold_sw10,
         short_threshold_sw9}, 13'h0053);
    host.rd(8'h08);
    chk(reg_rdata_q, 13'h0000);
    $display("test threshold registers done");
    host.wr(OFF_SERIAL, 13'h1fff);
    host.rd(OFF_SERIAL);
    chk(reg_rdata_q, 13'h03ff);
    host.cl(6'h3f);
    chk({12'h000, cluster_accept_q}, 13'h0001);
    @(posedge clk);
    #1 host.cl(6'h01);
    chk({12'h000, cluster_accept_q}, 13'h0000);
    $display("test serial config done");
    for (int i = 0; i < 3; i++) begin
      n = nt[i] * TL;
      host.wr(OFF_SERIAL, {3'h0, sel[i], 6'h05});
      repeat (n - 3) @(posedge clk);
      #1 host.cmd();
      repeat (n) @(posedge clk);
      #1 chk({12'h000, link_timeout_status_q}, 13'h0000);
      chk({1'b0, switch_drive_q}, {1'b0, normal_switch_state});
      @(posedge clk);
      #1 chk({12'h000, link_timeout_status_q}, 13'h0001);
      @(posedge clk);
      #1 chk({12'h000, fault_output_q}, 13'h0001);
      chk({1'b0, switch_drive_q}, {1'b0, timeout_switch_pattern});
      host.cmd();
      chk({12'h000, link_timeout_status_q}, 13'h0000);
      chk({12'h000, fault_output_q}, 13'h0001);
      @(posedge clk);
      #1 chk({12'h000, fault_output_q}, 13'h0000);
      chk({1'b0, switch_drive_q}, {1'b0, normal_switch_state});
    end
    $display("test link watchdog done");
    host.wr(OFF_SERIAL, 13'h0005);
    repeat (60) @(posedge clk);
    #1 chk({12'h000, link_timeout_status_q}, 13'h0000);
    $display("test watchdog disabled done");
    host.wr(OFF_SHORT_HI, 13'h0fff);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    host.rd(OFF_SHORT_HI);
    chk(reg_rdata_q, 13'h0000);
    host.rd(OFF_SERIAL);
    chk(reg_rdata_q, 13'h0001);
    $display("test mid-run reset done");
    test_done;
  end
endmodule
`default_nettype wire
